// File: src/uvrd_map.svh
// Named constants of the vendor request decoder: request types, codes, offsets, limits.
// Assumes inclusion by bare name from every file that needs them.
`ifndef UVRD_MAP_SVH
`define UVRD_MAP_SVH

// ****************************************************************
// Request framing
// ****************************************************************
`define UVRD_CTRL_EP       4'h0
`define UVRD_RT_OUT        8'h40
`define UVRD_RT_IN         8'hc0
`define UVRD_TYPE_VENDOR   2'h2

// ****************************************************************
// Command codes
// ****************************************************************
`define UVRD_CMD_HALT      8'h89
`define UVRD_CMD_STEP      8'h94
`define UVRD_CMD_TARGET    8'he0
`define UVRD_CMD_GETVAR    8'ha1
`define UVRD_CMD_SETSET    8'h13

// ****************************************************************
// Offsets, values and limits
// ****************************************************************
`define UVRD_SET_STEP_OFS  16'h0041
`define UVRD_VAR_TGT_OFS   17'h0000a
`define UVRD_TGT_BYTES     17'h00004
`define UVRD_STEP_EIGHTH   7'h03
`define UVRD_LEN_MIN       16'h0001
`define UVRD_LEN_MAX       16'h0080
`define UVRD_RST_STEP      7'h00
`define UVRD_RST_SETSTEP   8'h00

`endif

// File: src/uvrd_pkg.sv
// Types shared by the vendor request decoder modules.
// Assumes the SETUP packet arrives as eight bytes, byte 0 in bits 7:0.
package uvrd_pkg;

   // Fields of one SETUP packet
   typedef struct packed {
      logic [15:0] wlength;
      logic [15:0] windex;
      logic [15:0] wvalue;
      logic [7:0]  req;
      logic [7:0]  rtype;
   } uvrd_setup_t;

   // Request class found by the decoder
   typedef enum logic [2:0] {
      K_NONE, K_QUICK, K_W7, K_W32, K_READ, K_SET, K_BAD
   } uvrd_kind_t;

   // Block read sequencer states
   typedef enum logic [1:0] {
      ST_IDLE, ST_FETCH, ST_LOAD, ST_SEND
   } uvrd_state_t;

endpackage : uvrd_pkg

// File: src/uvrd_if.sv
// Carrier between the decoder core, its request classifier and its variable memory.
// Assumes all users sit on one clock.
`timescale 1ns/1ns
interface uvrd_if #(
   parameter int AW = 8
);
   uvrd_pkg::uvrd_setup_t req;
   logic [3:0]            ep;
   uvrd_pkg::uvrd_kind_t  kind;
   logic                  rd_en;
   logic [AW-1:0]         rd_addr;
   logic [7:0]            rd_data;
   logic                  wr_en;
   logic [AW-1:0]         wr_addr;
   logic [7:0]            wr_data;

   modport core (output req, ep, rd_en, rd_addr, wr_en, wr_addr, wr_data,
                 input  kind, rd_data);
   modport dec  (input  req, ep, output kind);
   modport mem  (input  rd_en, rd_addr, wr_en, wr_addr, wr_data, output rd_data);
endinterface : uvrd_if

// File: src/uvrd_var_mem.sv
// Byte-wide variable memory read by block reads; read data come from a register.
// Assumes writes come from motor logic on the same clock.
`timescale 1ns/1ns
`include "uvrd_map.svh"
module uvrd_var_mem #(
   parameter int DEPTH = 256
) (
   input  wire logic ref_clk,
   input  wire logic rstn,
   uvrd_if.mem       m
);
   logic [7:0] mem_q [DEPTH];
   logic [7:0] rd_data_d;
   logic [7:0] rd_data_q;

   // Storage has no reset; contents are defined by the motor side
   always_ff @(posedge ref_clk) begin
      if (m.wr_en) begin
         mem_q[m.wr_addr] <= m.wr_data;
      end
   end

   // Read port holds its last byte between reads
   always_comb begin
      rd_data_d = m.rd_en ? mem_q[m.rd_addr] : rd_data_q;
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data_q <= 8'h00;
      end else begin
         rd_data_q <= rd_data_d;
      end
   end

   assign m.rd_data = rd_data_q;
endmodule : uvrd_var_mem

// File: src/uvrd_decode.sv
// Classifier of SETUP packets into command formats, purely combinational.
// Assumes the request fields are stable while setup_valid is high in the core.
`timescale 1ns/1ns
`include "uvrd_map.svh"
module uvrd_decode (
   uvrd_if.dec d
);
   logic ours;
   logic z_val;
   logic z_idx;
   logic z_len;
   logic len_ok;

   // Field checks shared among the formats
   assign ours   = (d.ep == `UVRD_CTRL_EP) && (d.req.rtype[6:5] == `UVRD_TYPE_VENDOR);
   assign z_val  = (d.req.wvalue == 16'h0000);
   assign z_idx  = (d.req.windex == 16'h0000);
   assign z_len  = (d.req.wlength == 16'h0000);
   assign len_ok = (d.req.wlength >= `UVRD_LEN_MIN) && (d.req.wlength <= `UVRD_LEN_MAX);

   // Format selection by command code; any misfit stalls
   always_comb begin
      d.kind = uvrd_pkg::K_BAD;
      if (!ours) begin
         d.kind = uvrd_pkg::K_NONE;
      end else begin
         case (d.req.req)
            // R02 quick form
            `UVRD_CMD_HALT: begin
               if (d.req.rtype == `UVRD_RT_OUT && z_val && z_idx && z_len) begin
                  d.kind = uvrd_pkg::K_QUICK;
               end
            end
            // R03 seven-bit form
            `UVRD_CMD_STEP: begin
               if (d.req.rtype == `UVRD_RT_OUT && d.req.wvalue[15:7] == 9'h000
                   && z_idx && z_len) begin
                  d.kind = uvrd_pkg::K_W7;
               end
            end
            // R05 32-bit form
            `UVRD_CMD_TARGET: begin
               if (d.req.rtype == `UVRD_RT_OUT && z_len) begin
                  d.kind = uvrd_pkg::K_W32;
               end
            end
            // R06 block read form
            `UVRD_CMD_GETVAR: begin
               if (d.req.rtype == `UVRD_RT_IN && z_val && len_ok) begin
                  d.kind = uvrd_pkg::K_READ;
               end
            end
            // R11 setting write form
            `UVRD_CMD_SETSET: begin
               if (d.req.rtype == `UVRD_RT_OUT && d.req.wvalue[15:8] == 8'h00 && z_len) begin
                  d.kind = uvrd_pkg::K_SET;
               end
            end
            default: d.kind = uvrd_pkg::K_BAD;
         endcase
      end
   end
endmodule : uvrd_decode

// File: src/uvrd_top.sv
// Vendor control request decoder: turns SETUP packets into motor commands and
// serves block reads byte by byte. Assumes the USB function logic on ref_clk
// presents each SETUP packet as a one-cycle pulse and drains IN bytes by ready.
`timescale 1ns/1ns
`include "uvrd_map.svh"

// Operation
// R01 - Commands only as vendor requests, endpoint 0
// R02 - Quick: type 0x40, code only, zeros
// R03 - Seven-bit write: value below 0x80, zeros
// R04 - Code 0x94 sets step mode; 3 eighth
// R05 - 32-bit write: low wValue, high wIndex
// R06 - Block read: type 0xC0, wLength bytes returned
// R07 - Response starts at wIndex byte offset
// R08 - Host asks 1 to 128 bytes
// R09 - Multi-byte values sent low byte first
// R10 - Code 0xA1, offset 0x0A gives target
// R11 - Setting write: 8-bit value, offset wIndex
// R12 - Code 0x13 offset 0x41 sets step
// R13 - Stall unknown codes and bad lengths
module uvrd_top #(
   parameter int VAR_DEPTH = 256,
   parameter int AW        = $clog2(VAR_DEPTH)
) (
   input  wire logic          ref_clk,
   input  wire logic          rstn,
   input  wire logic          setup_valid,
   input  wire logic [63:0]   setup_pkt,
   input  wire logic [3:0]    setup_ep,
   input  wire logic          in_ready,
   input  wire logic          var_wr_en,
   input  wire logic [AW-1:0] var_wr_addr,
   input  wire logic [7:0]    var_wr_data,
   output logic               cmd_valid_q,
   output logic [7:0]         cmd_code_q,
   output logic [31:0]        cmd_data_q,
   output logic               set_valid_q,
   output logic [15:0]        set_offset_q,
   output logic [7:0]         set_value_q,
   output logic [6:0]         step_mode_q,
   output logic [7:0]         set_step_mode_q,
   output logic [31:0]        target_pos_q,
   output logic               ack_q,
   output logic               stall_q,
   output logic               in_valid_q,
   output logic [7:0]         in_data_q,
   output logic               in_last_q
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   uvrd_if #(.AW(AW)) bus ();

   uvrd_pkg::uvrd_setup_t req_s;
   uvrd_pkg::uvrd_state_t state_q, state_d;
   logic [15:0] ofs_q, ofs_d;
   logic [7:0]  idx_q, idx_d;
   logic [7:0]  len_q, len_d;
   logic [16:0] abs_addr;
   logic [15:0] rq_value;
   logic [15:0] rq_index;
   logic [7:0]  rq_code;
   logic [7:0]  tgt_lsb;
   logic        cmd_valid_d, set_valid_d, ack_d, stall_d;
   logic [7:0]  cmd_code_d, set_value_d, set_step_mode_d, in_data_d;
   logic [31:0] cmd_data_d, target_pos_d;
   logic [15:0] set_offset_d;
   logic [6:0]  step_mode_d;
   logic        in_valid_d, in_last_d;

   // ****************************************************************
   // Byte source for block reads
   // ****************************************************************
   // R10 target position overlay
   // Target position overlays the memory so it always reads its live value
   function automatic logic [7:0] resp_byte(input logic [16:0] a, input logic [31:0] tgt,
                                            input logic [7:0] memd);
      logic [16:0] rel;
      rel = 17'(a - `UVRD_VAR_TGT_OFS);
      if (a >= `UVRD_VAR_TGT_OFS && rel < `UVRD_TGT_BYTES) begin
         // R09 low byte first
         resp_byte = 8'(tgt >> {rel[1:0], 3'h0});
      end else if (a < 17'(VAR_DEPTH)) begin
         resp_byte = memd;
      end else begin
         resp_byte = 8'h00;
      end
   endfunction : resp_byte

   assign req_s    = setup_pkt;
   assign rq_value = req_s.wvalue;
   assign rq_index = req_s.windex;
   assign rq_code  = req_s.req;
   assign tgt_lsb  = target_pos_q[7:0];
   // R07 offset plus running index
   assign abs_addr = 17'({1'b0, ofs_q} + {9'h000, idx_q});

   assign bus.req     = req_s;
   assign bus.ep      = setup_ep;
   assign bus.rd_en   = (state_q == uvrd_pkg::ST_FETCH);
   assign bus.rd_addr = abs_addr[AW-1:0];
   assign bus.wr_en   = var_wr_en;
   assign bus.wr_addr = var_wr_addr;
   assign bus.wr_data = var_wr_data;

   uvrd_decode u_dec (
      .d (bus.dec)
   );

   uvrd_var_mem #(.DEPTH(VAR_DEPTH)) u_mem (
      .ref_clk (ref_clk),
      .rstn    (rstn),
      .m       (bus.mem)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   // A new SETUP of any kind but K_NONE aborts a running read, as the host has given up on it
   always_comb begin
      state_d         = state_q;
      ofs_d           = ofs_q;
      idx_d           = idx_q;
      len_d           = len_q;
      cmd_valid_d     = 1'b0;
      cmd_code_d      = cmd_code_q;
      cmd_data_d      = cmd_data_q;
      set_valid_d     = 1'b0;
      set_offset_d    = set_offset_q;
      set_value_d     = set_value_q;
      step_mode_d     = step_mode_q;
      set_step_mode_d = set_step_mode_q;
      target_pos_d    = target_pos_q;
      ack_d           = 1'b0;
      stall_d         = 1'b0;
      in_valid_d      = in_valid_q;
      in_data_d       = in_data_q;
      in_last_d       = in_last_q;
      case (state_q)
         uvrd_pkg::ST_FETCH: begin
            state_d = uvrd_pkg::ST_LOAD;
         end
         uvrd_pkg::ST_LOAD: begin
            in_valid_d = 1'b1;
            in_data_d  = resp_byte(abs_addr, target_pos_q, bus.rd_data);
            // R06 last byte at wLength
            in_last_d  = (8'(idx_q + 8'h01) == len_q);
            state_d    = uvrd_pkg::ST_SEND;
         end
         uvrd_pkg::ST_SEND: begin
            if (in_ready) begin
               in_valid_d = 1'b0;
               idx_d      = 8'(idx_q + 8'h01);
               state_d    = in_last_q ? uvrd_pkg::ST_IDLE : uvrd_pkg::ST_FETCH;
            end
         end
         default: state_d = uvrd_pkg::ST_IDLE;
      endcase
      // R01 only vendor requests on endpoint 0 reach here
      if (setup_valid && bus.kind != uvrd_pkg::K_NONE) begin
         in_valid_d = 1'b0;
         in_last_d  = 1'b0;
         state_d    = uvrd_pkg::ST_IDLE;
         case (bus.kind)
            uvrd_pkg::K_QUICK, uvrd_pkg::K_W7, uvrd_pkg::K_W32: begin
               cmd_valid_d = 1'b1;
               ack_d       = 1'b1;
               cmd_code_d  = rq_code;
               // R05 value split across wValue and wIndex
               cmd_data_d  = {rq_index, rq_value};
               // R04 step mode command
               if (bus.kind == uvrd_pkg::K_W7 && rq_code == `UVRD_CMD_STEP) begin
                  step_mode_d = rq_value[6:0];
               end
               if (bus.kind == uvrd_pkg::K_W32 && rq_code == `UVRD_CMD_TARGET) begin
                  target_pos_d = {rq_index, rq_value};
               end
            end
            uvrd_pkg::K_SET: begin
               set_valid_d  = 1'b1;
               ack_d        = 1'b1;
               set_offset_d = rq_index;
               set_value_d  = rq_value[7:0];
               // R12 stored step mode setting
               if (rq_index == `UVRD_SET_STEP_OFS) begin
                  set_step_mode_d = rq_value[7:0];
               end
            end
            uvrd_pkg::K_READ: begin
               // R07 start at requested offset
               ofs_d   = rq_index;
               idx_d   = 8'h00;
               len_d   = req_s.wlength[7:0];
               state_d = uvrd_pkg::ST_FETCH;
            end
            default: begin
               // R13 refuse by stalling
               stall_d = 1'b1;
            end
         endcase
      end
   end

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Every output is a flop so the USB logic sees clean edges
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         state_q         <= uvrd_pkg::ST_IDLE;
         ofs_q           <= 16'h0000;
         idx_q           <= 8'h00;
         len_q           <= 8'h00;
         cmd_valid_q     <= 1'b0;
         cmd_code_q      <= 8'h00;
         cmd_data_q      <= 32'h0000_0000;
         set_valid_q     <= 1'b0;
         set_offset_q    <= 16'h0000;
         set_value_q     <= 8'h00;
         step_mode_q     <= `UVRD_RST_STEP;
         set_step_mode_q <= `UVRD_RST_SETSTEP;
         target_pos_q    <= 32'h0000_0000;
         ack_q           <= 1'b0;
         stall_q         <= 1'b0;
         in_valid_q      <= 1'b0;
         in_data_q       <= 8'h00;
         in_last_q       <= 1'b0;
      end else begin
         state_q         <= state_d;
         ofs_q           <= ofs_d;
         idx_q           <= idx_d;
         len_q           <= len_d;
         cmd_valid_q     <= cmd_valid_d;
         cmd_code_q      <= cmd_code_d;
         cmd_data_q      <= cmd_data_d;
         set_valid_q     <= set_valid_d;
         set_offset_q    <= set_offset_d;
         set_value_q     <= set_value_d;
         step_mode_q     <= step_mode_d;
         set_step_mode_q <= set_step_mode_d;
         target_pos_q    <= target_pos_d;
         ack_q           <= ack_d;
         stall_q         <= stall_d;
         in_valid_q      <= in_valid_d;
         in_data_q       <= in_data_d;
         in_last_q       <= in_last_d;
      end
   end

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // Handshakes counted apart from the sequencer, so the last flag is judged on its own
   logic [7:0] hs_cnt_q, hs_cnt_d;

   always_comb begin
      hs_cnt_d = hs_cnt_q;
      if (setup_valid && bus.kind != uvrd_pkg::K_NONE) begin
         hs_cnt_d = 8'h00;
      end else if (in_valid_q && in_ready) begin
         hs_cnt_d = 8'(hs_cnt_q + 8'h01);
      end
   end

   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         hs_cnt_q <= 8'h00;
      end else begin
         hs_cnt_q <= hs_cnt_d;
      end
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_stall_bad_req: assert property ( // R13
      setup_valid && bus.kind == uvrd_pkg::K_BAD |=> stall_q && !cmd_valid_q && !in_valid_q)
      else $error("bad request not stalled");

   a_ep_filter: assert property ( // R01
      setup_valid && setup_ep != `UVRD_CTRL_EP |=> !cmd_valid_q && !stall_q && !set_valid_q)
      else $error("request on other endpoint acted upon");

   a_quick_code: assert property ( // R02
      setup_valid && bus.kind == uvrd_pkg::K_QUICK
      |=> cmd_valid_q && cmd_code_q == $past(rq_code) && cmd_data_q == 32'h0000_0000
      ##1 (!cmd_valid_q || $past(setup_valid)))
      else $error("quick command not issued once");

   a_step_mode: assert property ( // R04
      setup_valid && bus.kind == uvrd_pkg::K_W7 && rq_code == `UVRD_CMD_STEP
      |=> step_mode_q == $past(rq_value[6:0]))
      else $error("step mode not taken");

   a_w32_split: assert property ( // R05
      setup_valid && bus.kind == uvrd_pkg::K_W32 && rq_code == `UVRD_CMD_TARGET
      |=> target_pos_q == {$past(rq_index), $past(rq_value)})
      else $error("32-bit value halves swapped");

   a_read_start: assert property ( // R07
      setup_valid && bus.kind == uvrd_pkg::K_READ
      |=> state_q == uvrd_pkg::ST_FETCH && ofs_q == $past(rq_index) && idx_q == 8'h00
      ##2 (in_valid_q || $past(setup_valid) || $past(setup_valid, 2)))
      else $error("block read did not start at offset");

   a_tgt_lsb_first: assert property ( // R10
      state_q == uvrd_pkg::ST_LOAD && abs_addr == `UVRD_VAR_TGT_OFS && !setup_valid
      |=> in_data_q == $past(tgt_lsb))
      else $error("target position low byte not first");

   a_hold_byte: assert property ( // R06
      in_valid_q && !in_ready && !setup_valid |=> in_valid_q && $stable(in_data_q))
      else $error("IN byte dropped before ready");

   a_read_count: assert property ( // R06
      in_valid_q && in_ready && in_last_q |-> 8'(hs_cnt_q + 8'h01) == len_q)
      else $error("block read length mismatch");

   a_set_step: assert property ( // R12
      setup_valid && bus.kind == uvrd_pkg::K_SET && rq_index == `UVRD_SET_STEP_OFS
      |=> set_valid_q && set_step_mode_q == $past(rq_value[7:0]))
      else $error("step mode setting not stored");

   c_quick: cover property (setup_valid && bus.kind == uvrd_pkg::K_QUICK);
   c_read_done: cover property (in_valid_q && in_ready && in_last_q && len_q == 8'h04);
   c_stall: cover property (stall_q);
   c_eighth: cover property (step_mode_q == `UVRD_STEP_EIGHTH);

endmodule : uvrd_top

// File: tb/uvrd_host_model.sv
// Host-side model: issues vendor SETUP packets and drains IN data stages.
// Assumes the bench calls its tasks and that ref_clk runs; drives on falling edges.
`timescale 1ns/1ns
module uvrd_host_model (
   input  wire logic       ref_clk,
   output logic            setup_valid,
   output logic [63:0]     setup_pkt,
   output logic [3:0]      setup_ep,
   output logic            in_ready,
   input  wire logic       in_valid_q,
   input  wire logic [7:0] in_data_q,
   input  wire logic       in_last_q
);
   logic [7:0] rd_data [0:127];
   logic       rd_last [0:127];
   int         rd_fail;

   // Idle bus at time zero
   initial begin
      setup_valid = 1'b0;
      setup_pkt   = 64'h0;
      setup_ep    = 4'h0;
      in_ready    = 1'b0;
   end

   // ****************************************************************
   // SETUP issue
   // ****************************************************************
   // fields as the caller frames them
   task automatic send(input logic [3:0] ep, input logic [7:0] rt, input logic [7:0] rq,
                       input logic [15:0] wv, input logic [15:0] wi, input logic [15:0] wl);
      @(negedge ref_clk);
      setup_ep    = ep;
      setup_pkt   = {wl, wi, wv, rq, rt};
      setup_valid = 1'b1;
      @(negedge ref_clk);
      setup_valid = 1'b0;
      // Unqualified lines show a changed pattern so stale packets cannot pass
      setup_pkt   = ~setup_pkt;
      setup_ep    = ~setup_ep;
   endtask : send

   // ****************************************************************
   // IN data stage
   // ****************************************************************
   // caller keeps n within 1..128; slow mode stalls each byte
   task automatic drain(input int n, input bit slow);
      int w;
      rd_fail = 0;
      for (int k = 0; k < n; k++) begin
         w = 0;
         while (in_valid_q !== 1'b1 && w < 20) begin
            @(negedge ref_clk);
            w++;
         end
         if (w >= 20) rd_fail++;
         // A byte must stand while the host holds off
         if (slow) repeat (3) begin
            @(negedge ref_clk);
            if (in_valid_q !== 1'b1) rd_fail++;
         end
         rd_data[k] = in_data_q;
         rd_last[k] = in_last_q;
         in_ready   = 1'b1;
         @(negedge ref_clk);
         in_ready   = 1'b0;
      end
   endtask : drain
endmodule : uvrd_host_model

// File: tb/usb_vendor_request_decoder_tb.sv
// Self-checking bench of the vendor request decoder top.
// Assumes the host model drives SETUP and IN handshakes; bench drives memory writes.
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin n_errors++; \
   $display("mismatch %s expected %0h seen %0h", nm, ex, gt); end end
module usb_vendor_request_decoder_tb;
   logic        ref_clk, rstn, setup_valid, in_ready, var_wr_en;
   logic [63:0] setup_pkt;
   logic [3:0]  setup_ep, var_wr_addr;
   logic [7:0]  var_wr_data, cmd_code_q, set_value_q, set_step_mode_q, in_data_q;
   logic [31:0] cmd_data_q, target_pos_q;
   logic [15:0] set_offset_q;
   logic [6:0]  step_mode_q;
   logic        cmd_valid_q, set_valid_q, ack_q, stall_q, in_valid_q, in_last_q;
   int          n_errors = 0;
   int          n_checks = 0;

   uvrd_top #(.VAR_DEPTH(16)) dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .setup_valid(setup_valid), .setup_pkt(setup_pkt),
      .setup_ep(setup_ep), .in_ready(in_ready), .var_wr_en(var_wr_en),
      .var_wr_addr(var_wr_addr), .var_wr_data(var_wr_data), .cmd_valid_q(cmd_valid_q),
      .cmd_code_q(cmd_code_q), .cmd_data_q(cmd_data_q), .set_valid_q(set_valid_q),
      .set_offset_q(set_offset_q), .set_value_q(set_value_q), .step_mode_q(step_mode_q),
      .set_step_mode_q(set_step_mode_q), .target_pos_q(target_pos_q), .ack_q(ack_q),
      .stall_q(stall_q), .in_valid_q(in_valid_q), .in_data_q(in_data_q),
      .in_last_q(in_last_q));

   uvrd_host_model h (
      .ref_clk(ref_clk), .setup_valid(setup_valid), .setup_pkt(setup_pkt),
      .setup_ep(setup_ep), .in_ready(in_ready), .in_valid_q(in_valid_q),
      .in_data_q(in_data_q), .in_last_q(in_last_q));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // One-cycle answers are judged in the cycle they stand
   task automatic pulses(input logic c, input logic a, input logic s, input logic st);
      `CHK("cmd_valid", c, cmd_valid_q)
      `CHK("ack", a, ack_q)
      `CHK("set_valid", s, set_valid_q)
      `CHK("stall", st, stall_q)
   endtask : pulses

   task automatic chk_byte(input int k, input int n, input logic [7:0] e);
      `CHK("in_data", e, h.rd_data[k])
      `CHK("in_last", (k == n - 1), h.rd_last[k])
   endtask : chk_byte

   task automatic mem_wr(input logic [3:0] a, input logic [7:0] d);
      @(negedge ref_clk);
      var_wr_en   = 1'b1;
      var_wr_addr = a;
      var_wr_data = d;
      @(negedge ref_clk);
      var_wr_en   = 1'b0;
   endtask : mem_wr

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_quick;
      h.send(4'h0, 8'h40, 8'h89, 16'h0, 16'h0, 16'h0);
      pulses(1'b1, 1'b1, 1'b0, 1'b0);
      `CHK("cmd_code", 8'h89, cmd_code_q)
      `CHK("cmd_data", 32'h0, cmd_data_q)
      h.send(4'h1, 8'h40, 8'h89, 16'h0, 16'h0, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b0);
      h.send(4'h0, 8'h00, 8'h89, 16'h0, 16'h0, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b0);
      h.send(4'h0, 8'h40, 8'h89, 16'h1, 16'h0, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      h.send(4'h0, 8'h40, 8'h55, 16'h0, 16'h0, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
   endtask : t_quick

   task automatic t_writes;
      h.send(4'h0, 8'h40, 8'h94, 16'h0003, 16'h0, 16'h0);
      pulses(1'b1, 1'b1, 1'b0, 1'b0);
      `CHK("step_mode", 7'h03, step_mode_q)
      `CHK("cmd_code", 8'h94, cmd_code_q)
      h.send(4'h0, 8'h40, 8'h94, 16'h0080, 16'h0, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      `CHK("step_mode", 7'h03, step_mode_q)
      h.send(4'h0, 8'h40, 8'he0, 16'h02d2, 16'h4996, 16'h0);
      pulses(1'b1, 1'b1, 1'b0, 1'b0);
      `CHK("target_pos", 32'h499602d2, target_pos_q)
      `CHK("cmd_data", 32'h499602d2, cmd_data_q)
      h.send(4'h0, 8'h40, 8'he0, 16'h1111, 16'h2222, 16'h0001);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      `CHK("target_pos", 32'h499602d2, target_pos_q)
   endtask : t_writes

   task automatic t_setting;
      h.send(4'h0, 8'h40, 8'h13, 16'h0003, 16'h0041, 16'h0);
      pulses(1'b0, 1'b1, 1'b1, 1'b0);
      `CHK("set_offset", 16'h0041, set_offset_q)
      `CHK("set_value", 8'h03, set_value_q)
      `CHK("set_step_mode", 8'h03, set_step_mode_q)
      h.send(4'h0, 8'h40, 8'h13, 16'h0100, 16'h0041, 16'h0);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
   endtask : t_setting

   task automatic t_read_target;
      logic [7:0] e [0:3];
      e = '{8'hd2, 8'h02, 8'h96, 8'h49};
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h000a, 16'h0004);
      h.drain(4, 1'b1);
      `CHK("read_fail", 0, h.rd_fail)
      for (int k = 0; k < 4; k++) chk_byte(k, 4, e[k]);
   endtask : t_read_target

   task automatic t_read_mem;
      mem_wr(4'h2, 8'h5a);
      mem_wr(4'h3, 8'ha5);
      mem_wr(4'h4, 8'h3c);
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h0003, 16'h0002);
      h.drain(2, 1'b0);
      `CHK("read_fail", 0, h.rd_fail)
      chk_byte(0, 2, 8'ha5);
      chk_byte(1, 2, 8'h3c);
      // A new setup drops a byte that is still waiting for the host
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h0003, 16'h0002);
      repeat (3) @(negedge ref_clk);
      `CHK("in_data", 8'ha5, in_data_q)
      h.send(4'h0, 8'h40, 8'h89, 16'h0, 16'h0, 16'h0);
      `CHK("in_valid_abort", 1'b0, in_valid_q)
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h0, 16'h0000);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h0, 16'h0081);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0001, 16'h0, 16'h0001);
      pulses(1'b0, 1'b0, 1'b0, 1'b1);
      // Longest legal read, placed past the memory so every byte is zero
      h.send(4'h0, 8'hc0, 8'ha1, 16'h0, 16'h0100, 16'h0080);
      h.drain(128, 1'b0);
      `CHK("read_fail", 0, h.rd_fail)
      for (int k = 0; k < 128; k++) chk_byte(k, 128, 8'h00);
      repeat (3) @(negedge ref_clk);
      `CHK("in_valid_idle", 1'b0, in_valid_q)
   endtask : t_read_mem

   task automatic tally_and_finish;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : tally_and_finish

   // ****************************************************************
   // Clock, reset, sequence and watchdog
   // ****************************************************************
   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   initial begin
      rstn        = 1'b0;
      var_wr_en   = 1'b0;
      var_wr_addr = 4'h0;
      var_wr_data = 8'h00;
      repeat (20) @(negedge ref_clk);
      rstn = 1'b1;
      t_quick();
      t_writes();
      t_setting();
      t_read_target();
      t_read_mem();
      tally_and_finish();
   end

   // Whole run is near five hundred cycles; five thousand means a hang
   initial begin
      #100000;
      n_errors++;
      tally_and_finish();
   end
endmodule : usb_vendor_request_decoder_tb
